// ==== design/drbs_pkg.sv ====
// Shared constants and types for the DRAM board bus slave port and its bus master
package drbs_pkg;
  // ==========================================================
  // Bus geometry
  localparam int ADDR_W     = 20;
  localparam int PAGE_W     = 4;
  localparam int DATA_W     = 16;
  localparam int INT_LINES  = 8;
  localparam int BYTE_W     = 8;
  localparam int IO_ADDR_W  = 8;

  // ==========================================================
  // Configuration defaults
  localparam int BASE_4K_DEFAULT  = 0;
  localparam int PAGE_DEFAULT     = 0;
  localparam int IO_PORT_DEFAULT  = 8'h80;
  localparam int INT_SEL_DEFAULT  = 5;
  localparam int MEM_WORDS_DEFAULT = 8192;
  localparam int CAP_KB_DEFAULT   = 16;

  // ==========================================================
  // Parity flag port layout and reset value
  localparam int FLAG_EVEN_BIT = 0;
  localparam int FLAG_ODD_BIT  = 1;
  localparam int FLAG_W        = 2;
  localparam logic [1:0] FLAG_RESET = 2'h0;

  // ==========================================================
  // Timing in ns, as specified
  localparam int CLK_PERIOD_NS      = 50;
  localparam int T_MRD_ACK_SMALL_NS = 406;
  localparam int T_MRD_ACK_128K_NS  = 500;
  localparam int T_MRD_ACK_256K_NS  = 570;
  localparam int T_MWR_ACK_NS       = 343;
  localparam int T_MWR_ACK_256K_NS  = 363;
  localparam int T_IORD_ACK_SMALL_NS = 238;
  localparam int T_IORD_ACK_128K_NS = 330;
  localparam int T_IORD_ACK_256K_NS = 370;
  localparam int T_IOWR_ACK_NS      = 185;
  localparam int T_NQ_DATA_NS       = 600;
  localparam int T_REFRESH_NS       = 480;
  localparam int T_REFRESH_INT_NS   = 10560;
  localparam int T_CMD_SEP_NS       = 50;

  // ==========================================================
  // Cycle counts: longest times round down, least times round up
  localparam int MRD_ACK_SMALL_CYC  = T_MRD_ACK_SMALL_NS / CLK_PERIOD_NS;
  localparam int MRD_ACK_128K_CYC   = T_MRD_ACK_128K_NS / CLK_PERIOD_NS;
  localparam int MRD_ACK_256K_CYC   = T_MRD_ACK_256K_NS / CLK_PERIOD_NS;
  localparam int MWR_ACK_CYC        = T_MWR_ACK_NS / CLK_PERIOD_NS;
  localparam int MWR_ACK_256K_CYC   = T_MWR_ACK_256K_NS / CLK_PERIOD_NS;
  localparam int IORD_ACK_SMALL_CYC = T_IORD_ACK_SMALL_NS / CLK_PERIOD_NS;
  localparam int IORD_ACK_128K_CYC  = T_IORD_ACK_128K_NS / CLK_PERIOD_NS;
  localparam int IORD_ACK_256K_CYC  = T_IORD_ACK_256K_NS / CLK_PERIOD_NS;
  localparam int IOWR_ACK_CYC       = T_IOWR_ACK_NS / CLK_PERIOD_NS;
  localparam int NQ_DATA_CYC        = (T_NQ_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_CYC        = (T_REFRESH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REFRESH_INT_CYC    = T_REFRESH_INT_NS / CLK_PERIOD_NS;
  localparam int CMD_SEP_CYC        = (T_CMD_SEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMEOUT_DEFAULT    = 64;

  // ==========================================================
  // Bus command kinds
  typedef enum logic [1:0] {CMD_MRD, CMD_MWR, CMD_IORD, CMD_IOWR} drbs_cmd_t;
endpackage

// ==== design/drbs_bus_if.sv ====
// Interface joining the bus master end and the DRAM board slave end
`timescale 1ns/1ps
`default_nettype none
interface drbs_bus_if;
  logic [drbs_pkg::ADDR_W-1:0]    adr_n;
  logic [drbs_pkg::PAGE_W-1:0]    page_n;
  logic                           bhen_n;
  logic                           mrdc_n;
  logic                           mwtc_n;
  logic                           iorc_n;
  logic                           iowc_n;
  logic                           inh_n;
  logic                           write_guard_n;
  logic                           ext_refresh_req_n;
  logic                           init_n;
  logic [drbs_pkg::DATA_W-1:0]    dat_m_n;
  logic                           dat_m_oe;
  logic [drbs_pkg::DATA_W-1:0]    dat_s_n;
  logic                           dat_s_oe;
  logic [drbs_pkg::DATA_W-1:0]    dat_n;
  logic                           xack_n;
  logic [drbs_pkg::INT_LINES-1:0] int_n;
  logic                           parity_even_byte;
  logic                           parity_odd_byte;

  // Wired level of the shared data lines: any driver pulling low wins
  assign dat_n = (dat_m_oe ? dat_m_n : '1) & (dat_s_oe ? dat_s_n : '1);

  modport master (
    output adr_n, page_n, bhen_n, mrdc_n, mwtc_n, iorc_n, iowc_n, inh_n,
    output write_guard_n, ext_refresh_req_n, init_n, dat_m_n, dat_m_oe,
    input  dat_n, xack_n, int_n, parity_even_byte, parity_odd_byte
  );
  modport slave (
    input  adr_n, page_n, bhen_n, mrdc_n, mwtc_n, iorc_n, iowc_n, inh_n,
    input  write_guard_n, ext_refresh_req_n, init_n, dat_n,
    output dat_s_n, dat_s_oe, xack_n, int_n, parity_even_byte, parity_odd_byte
  );
endinterface
`default_nettype wire

// ==== design/drbs_parity.sv ====
// Per-byte even parity generator used for write generation and read checking
`timescale 1ns/1ps
`default_nettype none
module drbs_parity #(
  parameter int DATA_W = drbs_pkg::DATA_W
) (
  input  wire logic [DATA_W-1:0]                  data_in,
  output logic      [DATA_W/drbs_pkg::BYTE_W-1:0] par_out
);
  // ==========================================================
  // One parity bit per byte lane
  for (genvar b = 0; b < DATA_W / drbs_pkg::BYTE_W; b++) begin : g_lane
    assign par_out[b] = ^data_in[b*drbs_pkg::BYTE_W +: drbs_pkg::BYTE_W];
  end
endmodule
`default_nettype wire

// ==== design/drbs_slave.sv ====
// DRAM board bus slave port: decode, storage, timing, refresh, parity and interrupt
//
// Overview of operation
// [RULE_01] Decode all 20 address lines, top MSB
// [RULE_02] Even address uses data lines 0-7
// [RULE_03] Byte high enable moves odd byte on 8-15
// [RULE_04] 16 active-low data lines, top bit MSB
// [RULE_05] Inhibit suppresses any answer to memory access
// [RULE_06] Memory read drives stored word onto bus
// [RULE_07] Memory write stores bus data per lane
// [RULE_08] I/O read returns on-board port contents
// [RULE_09] I/O write loads on-board port value
// [RULE_10] Acknowledge only with data valid or taken
// [RULE_11] Memory protect ignores commands, no acknowledge
// [RULE_12] Upper four lines select one megabyte page
// [RULE_13] Output generated parity bit per byte
// [RULE_14] Accept external refresh request as timing source
// [RULE_15] Drive one of eight active-low interrupt lines
// [RULE_16] Memory read acknowledge by 406/500/570 ns
// [RULE_17] Memory write acknowledge by 343/363 ns
// [RULE_18] I/O read acknowledge by 238/330/370 ns
// [RULE_19] Advanced write latches data after 600 ns
// [RULE_20] Read parity outcome kept in readable port
// [RULE_21] Parity error raises selected line, default five
// [RULE_22] Master supplies page lines outside page zero
// [RULE_23] Refresh in progress finishes before access acknowledge
// [RULE_24] Reset aborts access, releases lines, clears flags
`timescale 1ns/1ps
`default_nettype none
module drbs_slave #(
  parameter int MEM_WORDS      = drbs_pkg::MEM_WORDS_DEFAULT,
  parameter int CAP_KB         = drbs_pkg::CAP_KB_DEFAULT,
  parameter int BASE_4K        = drbs_pkg::BASE_4K_DEFAULT,
  parameter int PAGE           = drbs_pkg::PAGE_DEFAULT,
  parameter int IO_PORT        = drbs_pkg::IO_PORT_DEFAULT,
  parameter int INT_SEL        = drbs_pkg::INT_SEL_DEFAULT,
  parameter bit PARITY_EN      = 1'b1,
  parameter bit EXT_REFRESH_EN = 1'b0,
  parameter bit NQ_WRITE       = 1'b0
) (
  input  wire logic   sys_clk_in,
  input  wire logic   sys_rst_in,
  drbs_bus_if.slave   bus,
  output logic        parity_led_out,
  output logic        busy_out
);
  localparam int DW    = drbs_pkg::DATA_W;
  localparam int AW    = drbs_pkg::ADDR_W;
  localparam int BW    = drbs_pkg::BYTE_W;
  localparam int IDX_W = $clog2(MEM_WORDS);
  localparam logic [AW:0] BASE_ADDR = {1'b0, BASE_4K[7:0], 12'h000};
  localparam logic [AW:0] MEM_BYTES = (AW+1)'(MEM_WORDS * 2);
  // Acknowledge deadlines per capacity version
  localparam int MRD_CYC  = CAP_KB >= 256 ? drbs_pkg::MRD_ACK_256K_CYC :
                            CAP_KB >= 128 ? drbs_pkg::MRD_ACK_128K_CYC : drbs_pkg::MRD_ACK_SMALL_CYC;
  localparam int IORD_CYC = CAP_KB >= 256 ? drbs_pkg::IORD_ACK_256K_CYC :
                            CAP_KB >= 128 ? drbs_pkg::IORD_ACK_128K_CYC : drbs_pkg::IORD_ACK_SMALL_CYC;
  localparam int MWR_CYC  = NQ_WRITE ? drbs_pkg::NQ_DATA_CYC + 1 :
                            CAP_KB >= 256 ? drbs_pkg::MWR_ACK_256K_CYC : drbs_pkg::MWR_ACK_CYC;

  typedef enum {ST_IDLE, ST_REFRESH, ST_WAIT, ST_HOLD} drbs_state_t;

  // ==========================================================
  // Storage: data word plus two stored parity bits
  logic [DW+1:0]             mem [MEM_WORDS];
  drbs_state_t               state_r;
  logic [4:0]                cnt_r;
  drbs_pkg::drbs_cmd_t       kind_r;
  logic [IDX_W-1:0]          idx_r;
  logic                      even_r;
  logic                      odd_r;
  logic                      swap_r;
  logic [7:0]                ref_cnt_r;
  logic                      ref_pend_r;
  logic                      ext_req_prev_r;
  logic [drbs_pkg::FLAG_W-1:0] flag_r;
  logic [drbs_pkg::INT_LINES-1:0] int_n_r;
  logic [DW-1:0]             dat_s_n_r;
  logic                      dat_s_oe_r;
  logic                      xack_n_r;
  logic                      par_even_r;
  logic                      par_odd_r;

  logic              rst;
  logic [AW-1:0]     addr;
  logic [DW-1:0]     bus_data;
  logic [AW:0]       offset;
  logic              mem_hit;
  logic              io_hit;
  logic              mrd;
  logic              mwr;
  logic              iord;
  logic              iowr;
  logic              cmd_any;
  logic              done;
  logic [DW+1:0]     rd_word;
  logic [DW-1:0]     wr_word;
  logic [1:0]        wr_par;
  logic [1:0]        rd_calc;
  logic [1:0]        par_err;
  logic [DW-1:0]     rd_out;

  // ==========================================================
  // Decode of the active-low bus
  assign rst      = sys_rst_in | ~bus.init_n; // RULE_24
  assign addr     = ~bus.adr_n; // RULE_01
  assign bus_data = ~bus.dat_n; // RULE_04
  assign offset   = {1'b0, addr} - BASE_ADDR;
  assign mem_hit  = (~bus.page_n == PAGE[drbs_pkg::PAGE_W-1:0]) // RULE_12
                    && ({1'b0, addr} >= BASE_ADDR) && (offset < MEM_BYTES);
  assign io_hit   = addr[drbs_pkg::IO_ADDR_W-1:0] == IO_PORT[drbs_pkg::IO_ADDR_W-1:0];
  assign mrd      = ~bus.mrdc_n;
  assign mwr      = ~bus.mwtc_n;
  assign iord     = ~bus.iorc_n;
  assign iowr     = ~bus.iowc_n;
  assign cmd_any  = mrd | mwr | iord | iowr;
  assign done     = (state_r == ST_WAIT) && (cnt_r == 5'h0) && cmd_any;

  // Read-modify-write merge keeps the unselected lane intact
  assign rd_word  = mem[idx_r];
  assign wr_word[DW-1:BW] = odd_r ? (swap_r ? bus_data[BW-1:0] : bus_data[DW-1:BW]) // RULE_03
                                  : rd_word[DW-1:BW];
  assign wr_word[BW-1:0]  = even_r ? bus_data[BW-1:0] : rd_word[BW-1:0]; // RULE_02
  assign rd_out   = swap_r ? {rd_word[DW-1:BW], rd_word[DW-1:BW]} : rd_word[DW-1:0];
  assign par_err  = {odd_r & (rd_word[DW+1] ^ rd_calc[1]), even_r & (rd_word[DW] ^ rd_calc[0])};

  drbs_parity #(.DATA_W(DW)) u_par_wr (.data_in(wr_word), .par_out(wr_par));
  drbs_parity #(.DATA_W(DW)) u_par_rd (.data_in(rd_word[DW-1:0]), .par_out(rd_calc));

  // ==========================================================
  // Access sequencer: refresh first, then the latched command
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      state_r <= ST_IDLE; // RULE_24
      cnt_r   <= 5'h0;
      kind_r  <= drbs_pkg::CMD_MRD;
      idx_r   <= '0;
      even_r  <= 1'b0;
      odd_r   <= 1'b0;
      swap_r  <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (ref_pend_r) begin
            state_r <= ST_REFRESH; // RULE_23
            cnt_r   <= 5'(drbs_pkg::REFRESH_CYC - 1);
          end else if (cmd_any && bus.write_guard_n) begin // RULE_11
            idx_r  <= offset[IDX_W:1];
            even_r <= ~addr[0];
            odd_r  <= addr[0] | ~bus.bhen_n;
            swap_r <= addr[0] & bus.bhen_n;
            // Deadline less two: the command is one edge old here, the ack launches one edge later
            if ((mrd || mwr) && mem_hit && bus.inh_n) begin // RULE_05
              state_r <= ST_WAIT;
              kind_r  <= mrd ? drbs_pkg::CMD_MRD : drbs_pkg::CMD_MWR;
              cnt_r   <= mrd ? 5'(MRD_CYC - 2) : 5'(MWR_CYC - 2); // RULE_16 RULE_17 RULE_19
            end else if ((iord || iowr) && io_hit) begin
              state_r <= ST_WAIT;
              kind_r  <= iord ? drbs_pkg::CMD_IORD : drbs_pkg::CMD_IOWR;
              cnt_r   <= iord ? 5'(IORD_CYC - 2) : 5'(drbs_pkg::IOWR_ACK_CYC - 2); // RULE_18
            end
          end
        end
        ST_REFRESH: begin
          cnt_r <= cnt_r - 5'h1;
          if (cnt_r == 5'h0) begin
            state_r <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          cnt_r <= cnt_r - 5'h1;
          if (!cmd_any) begin
            state_r <= ST_IDLE; // Master withdrew: abandon quietly
          end else if (cnt_r == 5'h0) begin
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!cmd_any) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Acknowledge and read data, asserted on the same edge
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      xack_n_r   <= 1'b1; // RULE_24
      dat_s_oe_r <= 1'b0;
      dat_s_n_r  <= '1;
    end else if (done) begin
      xack_n_r <= 1'b0; // RULE_10
      if (kind_r == drbs_pkg::CMD_MRD) begin
        dat_s_n_r  <= ~rd_out; // RULE_06
        dat_s_oe_r <= 1'b1;
      end else if (kind_r == drbs_pkg::CMD_IORD) begin
        dat_s_n_r  <= ~{{(DW - drbs_pkg::FLAG_W){1'b0}}, flag_r}; // RULE_08
        dat_s_oe_r <= 1'b1;
      end
    end else if (state_r == ST_HOLD && !cmd_any) begin
      xack_n_r   <= 1'b1;
      dat_s_oe_r <= 1'b0;
      dat_s_n_r  <= '1;
    end
  end

  // ==========================================================
  // Array write; sampled at the deadline so late advanced data is caught
  always_ff @(posedge sys_clk_in) begin
    if (!rst && done && kind_r == drbs_pkg::CMD_MWR) begin // RULE_24
      mem[idx_r] <= {wr_par, wr_word}; // RULE_07 RULE_19
    end
  end

  // ==========================================================
  // Parity flag port: a new error wins over a clearing write
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      flag_r <= drbs_pkg::FLAG_RESET; // RULE_24
    end else begin
      flag_r <= ((done && kind_r == drbs_pkg::CMD_IOWR) ? bus_data[drbs_pkg::FLAG_W-1:0] : flag_r) // RULE_09
                | ((done && kind_r == drbs_pkg::CMD_MRD && PARITY_EN) ? par_err : 2'h0); // RULE_20
    end
  end

  // ==========================================================
  // Parity bits on the auxiliary lines, from the last array access
  always_ff @(posedge sys_clk_in) begin
    if (rst || !PARITY_EN) begin
      par_even_r <= 1'b0;
      par_odd_r  <= 1'b0;
    end else if (done && kind_r == drbs_pkg::CMD_MWR) begin
      par_even_r <= wr_par[0]; // RULE_13
      par_odd_r  <= wr_par[1];
    end else if (done && kind_r == drbs_pkg::CMD_MRD) begin
      par_even_r <= rd_word[DW];
      par_odd_r  <= rd_word[DW+1];
    end
  end

  // ==========================================================
  // Refresh source: internal interval, or falling edge of external request
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      ref_cnt_r      <= 8'h0;
      ref_pend_r     <= 1'b0;
      ext_req_prev_r <= 1'b1;
    end else begin
      ext_req_prev_r <= bus.ext_refresh_req_n;
      ref_cnt_r <= (ref_cnt_r == 8'(drbs_pkg::REFRESH_INT_CYC - 1)) ? 8'h0 : ref_cnt_r + 8'h1;
      // Request set wins over the clear on entering refresh
      if (EXT_REFRESH_EN ? (ext_req_prev_r && !bus.ext_refresh_req_n) // RULE_14
                         : (ref_cnt_r == 8'(drbs_pkg::REFRESH_INT_CYC - 1))) begin
        ref_pend_r <= 1'b1;
      end else if (state_r == ST_IDLE) begin
        ref_pend_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Interrupt lines: only the selected one may pull low
  for (genvar i = 0; i < drbs_pkg::INT_LINES; i++) begin : g_int
    always_ff @(posedge sys_clk_in) begin
      if (rst) begin
        int_n_r[i] <= 1'b1; // RULE_24
      end else begin
        int_n_r[i] <= ~((i == INT_SEL) && PARITY_EN && (|flag_r)); // RULE_15 RULE_21
      end
    end
  end

  // ==========================================================
  // Status pins for the user side
  always_ff @(posedge sys_clk_in) begin
    if (rst) begin
      parity_led_out <= 1'b0;
      busy_out       <= 1'b0;
    end else begin
      parity_led_out <= |flag_r;
      busy_out       <= state_r != ST_IDLE;
    end
  end

  assign bus.xack_n           = xack_n_r;
  assign bus.dat_s_n          = dat_s_n_r;
  assign bus.dat_s_oe         = dat_s_oe_r;
  assign bus.int_n            = int_n_r;
  assign bus.parity_even_byte = par_even_r;
  assign bus.parity_odd_byte  = par_odd_r;
endmodule
`default_nettype wire

// ==== design/drbs_master.sv ====
// Bus master end: runs one memory or I/O command per request and waits for acknowledge
`timescale 1ns/1ps
`default_nettype none
module drbs_master #(
  parameter int TIMEOUT_CYC = drbs_pkg::TIMEOUT_DEFAULT
) (
  input  wire logic                       sys_clk_in,
  input  wire logic                       sys_rst_in,
  drbs_bus_if.master                      bus,
  input  wire logic                       req_in,
  input  wire drbs_pkg::drbs_cmd_t        cmd_in,
  input  wire logic [drbs_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [drbs_pkg::PAGE_W-1:0] page_in,
  input  wire logic                       byte_hi_in,
  input  wire logic [drbs_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       inhibit_in,
  input  wire logic                       guard_in,
  input  wire logic                       refresh_in,
  input  wire logic                       init_in,
  output logic                            done_out,
  output logic                            timeout_out,
  output logic [drbs_pkg::DATA_W-1:0]      rdata_out,
  output logic                            busy_out
);
  typedef enum {M_IDLE, M_SETUP, M_CMD, M_SEP} drbs_mstate_t;

  drbs_mstate_t                  state_r;
  drbs_pkg::drbs_cmd_t           kind_r;
  logic [15:0]                   tmo_r;
  logic [drbs_pkg::ADDR_W-1:0]   adr_n_r;
  logic [drbs_pkg::PAGE_W-1:0]   page_n_r;
  logic                          bhen_n_r;
  logic [3:0]                    cmd_n_r;
  logic [drbs_pkg::DATA_W-1:0]   dat_n_r;
  logic                          dat_oe_r;
  logic                          aux_inh_n_r;
  logic                          aux_guard_n_r;
  logic                          aux_ref_n_r;
  logic                          aux_init_n_r;

  // ==========================================================
  // Command sequence: address first, command held until acknowledge or time-out
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      state_r     <= M_IDLE;
      kind_r      <= drbs_pkg::CMD_MRD;
      tmo_r       <= 16'h0;
      adr_n_r     <= '1;
      page_n_r    <= '1;
      bhen_n_r    <= 1'b1;
      cmd_n_r     <= 4'hf;
      dat_n_r     <= '1;
      dat_oe_r    <= 1'b0;
      done_out    <= 1'b0;
      timeout_out <= 1'b0;
      rdata_out   <= '0;
      busy_out    <= 1'b0;
    end else begin
      done_out    <= 1'b0;
      timeout_out <= 1'b0;
      case (state_r)
        M_IDLE: begin
          if (req_in) begin
            state_r  <= M_SETUP;
            kind_r   <= cmd_in;
            busy_out <= 1'b1;
            adr_n_r  <= ~addr_in; // RULE_01
            page_n_r <= ~page_in; // RULE_22
            bhen_n_r <= ~byte_hi_in;
            dat_n_r  <= ~wdata_in;
            dat_oe_r <= (cmd_in == drbs_pkg::CMD_MWR) || (cmd_in == drbs_pkg::CMD_IOWR);
          end
        end
        M_SETUP: begin
          // One cycle of address set-up before the strobe
          state_r <= M_CMD;
          tmo_r   <= 16'h0;
          cmd_n_r <= ~(4'h1 << kind_r);
        end
        M_CMD: begin
          tmo_r <= tmo_r + 16'h1;
          if (!bus.xack_n) begin
            state_r   <= M_SEP; // RULE_10
            cmd_n_r   <= 4'hf;
            dat_oe_r  <= 1'b0;
            done_out  <= 1'b1;
            rdata_out <= ~bus.dat_n;
          end else if (tmo_r == 16'(TIMEOUT_CYC - 1)) begin
            // Guarded or unclaimed access would otherwise hang the bus
            state_r     <= M_SEP;
            cmd_n_r     <= 4'hf;
            dat_oe_r    <= 1'b0;
            timeout_out <= 1'b1;
          end
        end
        M_SEP: begin
          state_r  <= M_IDLE;
          busy_out <= 1'b0;
        end
        default: state_r <= M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Side-band levels, registered so the bus sees clean edges
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      aux_inh_n_r   <= 1'b1;
      aux_guard_n_r <= 1'b1;
      aux_ref_n_r   <= 1'b1;
      aux_init_n_r  <= 1'b1;
    end else begin
      aux_inh_n_r   <= ~inhibit_in; // RULE_05
      aux_guard_n_r <= ~guard_in; // RULE_11
      aux_ref_n_r   <= ~refresh_in; // RULE_14
      aux_init_n_r  <= ~init_in;
    end
  end

  assign bus.adr_n             = adr_n_r;
  assign bus.page_n            = page_n_r;
  assign bus.bhen_n            = bhen_n_r;
  assign bus.mrdc_n            = cmd_n_r[0];
  assign bus.mwtc_n            = cmd_n_r[1];
  assign bus.iorc_n            = cmd_n_r[2];
  assign bus.iowc_n            = cmd_n_r[3];
  assign bus.dat_m_n           = dat_n_r;
  assign bus.dat_m_oe          = dat_oe_r;
  assign bus.inh_n             = aux_inh_n_r;
  assign bus.write_guard_n     = aux_guard_n_r;
  assign bus.ext_refresh_req_n = aux_ref_n_r;
  assign bus.init_n            = aux_init_n_r;
endmodule
`default_nettype wire

// ==== sim/drbs_chk.sv ====
// Concurrent checks on the bus joining the master end and the DRAM board slave end
`timescale 1ns/1ps
`default_nettype none
module drbs_chk (
  input wire logic       sys_clk_in,
  input wire logic       sys_rst_in,
  input wire logic       mrdc_n,
  input wire logic       mwtc_n,
  input wire logic       iorc_n,
  input wire logic       inh_n,
  input wire logic       write_guard_n,
  input wire logic       init_n,
  input wire logic       xack_n,
  input wire logic       dat_s_oe,
  input wire logic [7:0] int_n
);
  // ==========================================
  // Acknowledge timing; a refresh may add up to 11 cycles
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_late;
    ##[1:12] !xack_n;
  endsequence
  property p_mrd; $fell(mrdc_n) && write_guard_n && inh_n |-> xack_n[*8] ##0 s_late; endproperty
  a_mrd: assert property (p_mrd) else $error("memory read ack timing");
  property p_mwr; $fell(mwtc_n) && write_guard_n && inh_n |-> xack_n[*6] ##0 s_late; endproperty
  a_mwr: assert property (p_mwr) else $error("memory write ack timing");
  property p_iord; $fell(iorc_n) && write_guard_n |-> xack_n[*4] ##0 s_late; endproperty
  a_iord: assert property (p_iord) else $error("port read ack timing");
  // ==========================================
  // Refusals, data drive, reset and interrupt line choice
  property p_guard; $fell(mrdc_n) && !write_guard_n |-> xack_n[*8]; endproperty
  a_guard: assert property (p_guard) else $error("ack while protected");
  property p_inh; $fell(mwtc_n) && !inh_n |-> xack_n[*8]; endproperty
  a_inh: assert property (p_inh) else $error("ack while inhibited");
  property p_rdoe; !xack_n && (!mrdc_n || !iorc_n) |-> dat_s_oe; endproperty
  a_rdoe: assert property (p_rdoe) else $error("read ack without data");
  property p_init; !init_n |=> xack_n && (int_n == 8'hff); endproperty
  a_init: assert property (p_init) else $error("bus reset not honoured");
  property p_int; (int_n | 8'h20) == 8'hff; endproperty
  a_int: assert property (p_int) else $error("wrong interrupt line");
endmodule
`default_nettype wire

// ==== sim/dram_board_bus_slave_port_tb.sv ====
// Self-checking bench joining the bus master end to the DRAM board slave end
`timescale 1ns/1ps
`default_nettype none
module dram_board_bus_slave_port_tb;
  logic                sys_clk_in = 1'b0;
  logic                sys_rst_in = 1'b1;
  logic                req, bh, inhibit, guard, init, done, tmo, led, ok;
  drbs_pkg::drbs_cmd_t cmd;
  logic [19:0]         addr;
  logic [15:0]         wdata, rdata;
  int                  fails = 0, compares = 0, cyc = 0;
  // ==========================================
  // Clock, design ends and checker
  always #25 sys_clk_in = ~sys_clk_in;
  drbs_bus_if b ();
  drbs_slave drbs_slave_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .bus(b.slave),
    .parity_led_out(led), .busy_out());
  drbs_master #(.TIMEOUT_CYC(20)) drbs_master_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .bus(b.master), .req_in(req), .cmd_in(cmd), .addr_in(addr), .page_in(4'h0), .byte_hi_in(bh),
    .wdata_in(wdata), .inhibit_in(inhibit), .guard_in(guard), .refresh_in(1'b0), .init_in(init),
    .done_out(done), .timeout_out(tmo), .rdata_out(rdata), .busy_out());
  drbs_chk drbs_chk_i (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .mrdc_n(b.mrdc_n),
    .mwtc_n(b.mwtc_n), .iorc_n(b.iorc_n), .inh_n(b.inh_n), .write_guard_n(b.write_guard_n),
    .init_n(b.init_n), .xack_n(b.xack_n), .dat_s_oe(b.dat_s_oe), .int_n(b.int_n));
  // ==========================================
  // Shared compare, command and closing tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request is a level, so drop it before the master returns to idle
  task automatic op(input drbs_pkg::drbs_cmd_t c, input logic [19:0] a, input logic h, input logic [15:0] d);
    int n;
    @(negedge sys_clk_in);
    cmd = c;
    addr = a;
    bh = h;
    wdata = d;
    req = 1'b1;
    @(negedge sys_clk_in);
    req = 1'b0;
    n = 0;
    while (done !== 1'b1 && tmo !== 1'b1 && n < 60) begin
      @(negedge sys_clk_in);
      n++;
    end
    ok = (done === 1'b1);
    repeat (4) @(negedge sys_clk_in);
  endtask
  task automatic summarize;
    $display("fails=%0d compares=%0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_mem;
    op(drbs_pkg::CMD_MWR, 20'h00010, 1'b1, 16'h1234);
    chk({14'h0, b.parity_odd_byte, b.parity_even_byte}, 16'h0001);
    op(drbs_pkg::CMD_MWR, 20'h00010, 1'b0, 16'h00ab);
    op(drbs_pkg::CMD_MWR, 20'h00011, 1'b1, 16'hcd00);
    op(drbs_pkg::CMD_MRD, 20'h00010, 1'b1, 16'h0000);
    chk(rdata, 16'hcdab);
  endtask
  task automatic t_io;
    op(drbs_pkg::CMD_IOWR, 20'h00080, 1'b0, 16'h0003);
    op(drbs_pkg::CMD_IORD, 20'h00080, 1'b0, 16'h0000);
    chk(rdata, 16'h0003);
    chk({14'h0, b.int_n[5], led}, 16'h0001);
  endtask
  task automatic t_refuse;
    guard = 1'b1;
    op(drbs_pkg::CMD_MRD, 20'h00010, 1'b1, 16'h0000);
    chk({15'h0, ok}, 16'h0000);
    guard = 1'b0;
    inhibit = 1'b1;
    op(drbs_pkg::CMD_MWR, 20'h00010, 1'b1, 16'hffff);
    chk({15'h0, ok}, 16'h0000);
    inhibit = 1'b0;
    op(drbs_pkg::CMD_MRD, 20'h00010, 1'b1, 16'h0000);
    chk(rdata, 16'hcdab);
  endtask
  // Bus reset must clear the flags and free the interrupt line
  task automatic t_init;
    init = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    init = 1'b0;
    op(drbs_pkg::CMD_IORD, 20'h00080, 1'b0, 16'h0000);
    chk({rdata[14:0], b.int_n[5]}, 16'h0001);
  endtask
  // ==========================================
  // Main sequence and hang guard
  initial begin
    req = 1'b0;
    cmd = drbs_pkg::CMD_MRD;
    addr = 20'h00000;
    bh = 1'b0;
    wdata = 16'h0000;
    inhibit = 1'b0;
    guard = 1'b0;
    init = 1'b0;
    repeat (16) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    t_mem();
    t_io();
    t_refuse();
    t_init();
    summarize();
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
endmodule
`default_nettype wire
